// ===== logic/lrc_pkg.sv
// Package for the LCD reset, interface select and master/slave config block.
// Assumes a single 100 MHz clock domain; no software registers.
package lrc_pkg;
	// Host timing styles
	typedef enum logic {LRC_IF_80 = 1'b0, LRC_IF_68 = 1'b1} lrc_if_t;
	// Number of row-scan lines per group
	localparam int LRC_ROWS = 16;
	// Settle time of the reset pin level after an edge, in ns
	localparam int LRC_SETTLE_NS = 100;
	localparam int LRC_CLK_NS = 10;
	localparam logic [7:0] LRC_SETTLE_CYC = 8'((LRC_SETTLE_NS + LRC_CLK_NS - 1) / LRC_CLK_NS);
	// Reset pulse length given to the rest of the chip, in cycles
	localparam logic [7:0] LRC_PULSE_CYC = 8'h04;
	// Oscillator divider half-period for the frame toggle, in oscillator rising edges
	localparam logic [7:0] LRC_FRAME_HALF = 8'h10;
	// Reset values
	localparam logic LRC_RST_FRAME = 1'b0;
	localparam logic [3:0] LRC_RST_ROW = 4'h0;
endpackage

// ===== logic/lrc_edge_reset.sv
// Edge-triggered reset generator with settled-level interface capture.
// Assumes the reset/interface pin is synchronous to i_clk.
`timescale 1ns/1ps
module lrc_edge_reset (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// Pin
	input wire logic i_rst_if_pin,
	// Results
	output logic o_chip_reset,
	output lrc_pkg::lrc_if_t o_if_type
);
	logic pin_q;
	logic [7:0] settle_q;
	logic [7:0] pulse_q;
	logic edge_w;

	assign edge_w = i_rst_if_pin ^ pin_q;

	// Previous pin level
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pin_q <= 1'b0;
		end else if (i_ce) begin
			pin_q <= i_rst_if_pin;
		end
	end

	// Reset pulse on either edge, never on a level
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pulse_q <= 8'h00;
		end else if (i_ce) begin
			if (edge_w) begin
				pulse_q <= lrc_pkg::LRC_PULSE_CYC;
			end else if (pulse_q != 8'h00) begin
				pulse_q <= pulse_q - 8'h01;
			end
		end
	end
	assign o_chip_reset = (pulse_q != 8'h00);

	// Settle counter restarts at each edge, then latches the level once
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			settle_q <= 8'h00;
			o_if_type <= lrc_pkg::LRC_IF_80;
		end else if (i_ce) begin
			if (edge_w) begin
				settle_q <= lrc_pkg::LRC_SETTLE_CYC;
			end else if (settle_q == 8'h01) begin
				settle_q <= 8'h00;
				o_if_type <= lrc_pkg::lrc_if_t'(pin_q);
			end else if (settle_q != 8'h00) begin
				settle_q <= settle_q - 8'h01;
			end
		end
	end
endmodule // lrc_edge_reset

// ===== logic/lrc_config.sv
// Configuration pins of a dot-matrix LCD row/segment driver: edge reset,
// interface select, master/slave role, frame polarity and row numbering.
// Assumes all pins synchronous to i_clk; frame pin resolved by testbench.
`timescale 1ns/1ps
module lrc_config (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	// Reset / interface select pin and role strap
	input wire logic i_rst_if_pin,
	input wire logic i_master_strap,
	// Frame polarity pin, two-way
	input wire logic i_frame_polarity,
	output logic o_frame_polarity,
	output logic o_frame_polarity_oe_n,
	// Oscillator pins
	input wire logic i_oscillator_pin_a,
	input wire logic i_oscillator_pin_b,
	output logic o_oscillator_pin_b,
	output logic o_oscillator_pin_b_oe_n,
	// Status toward the core
	output logic o_chip_reset,
	output lrc_pkg::lrc_if_t o_if_type,
	output logic o_is_master,
	output logic o_bias_invert,
	// Row scan
	output logic o_row_scan_step,
	output logic [4:0] o_row_scan_index
);
	// --------------------------------------------------------------------
	// Reset and interface selection
	// --------------------------------------------------------------------
	lrc_edge_reset u_edge (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_ce(i_ce),
		.i_rst_if_pin(i_rst_if_pin),
		.o_chip_reset(o_chip_reset),
		.o_if_type(o_if_type)
	);

	// --------------------------------------------------------------------
	// Role, frame and oscillator
	// --------------------------------------------------------------------
	logic master_q;
	logic frame_q;
	logic osc_prev_q;
	logic [7:0] div_q;
	logic [3:0] row_q;
	logic tick_w;
	logic osc_in_w;

	// Role strap sampled at each chip reset
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			master_q <= 1'b0;
		end else if (i_ce && o_chip_reset) begin
			master_q <= i_master_strap;
		end
	end
	assign o_is_master = master_q;

	// Master clocks from pin a, slave from pin b; pin a ignored in slave
	assign osc_in_w = master_q ? i_oscillator_pin_a : i_oscillator_pin_b;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			osc_prev_q <= 1'b0;
		end else if (i_ce) begin
			osc_prev_q <= osc_in_w;
		end
	end
	assign tick_w = osc_in_w & ~osc_prev_q;

	// Master buffers its oscillator out on pin b
	assign o_oscillator_pin_b = osc_prev_q;
	assign o_oscillator_pin_b_oe_n = ~master_q;

	// Master frame toggle from divided oscillator
	always_ff @(posedge i_clk) begin
		if (i_reset || (i_ce && o_chip_reset)) begin
			div_q <= 8'h00;
			frame_q <= lrc_pkg::LRC_RST_FRAME;
		end else if (i_ce && tick_w) begin
			if (div_q == lrc_pkg::LRC_FRAME_HALF - 8'h01) begin
				div_q <= 8'h00;
				frame_q <= ~frame_q;
			end else begin
				div_q <= div_q + 8'h01;
			end
		end
	end
	assign o_frame_polarity = frame_q;
	assign o_frame_polarity_oe_n = ~master_q;

	// Bias polarity follows own frame or the master's
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_bias_invert <= 1'b0;
		end else if (i_ce) begin
			o_bias_invert <= master_q ? frame_q : i_frame_polarity;
		end
	end

	// --------------------------------------------------------------------
	// Row scan numbering and order
	// --------------------------------------------------------------------
	always_ff @(posedge i_clk) begin
		if (i_reset || (i_ce && o_chip_reset)) begin
			row_q <= lrc_pkg::LRC_RST_ROW;
		end else if (i_ce && tick_w) begin
			row_q <= row_q + 4'h1;
		end
	end

	// Master 0..15 ascending, slave 31..16 descending
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_row_scan_index <= 5'h00;
			o_row_scan_step <= 1'b0;
		end else if (i_ce) begin
			o_row_scan_step <= tick_w;
			if (master_q) begin
				o_row_scan_index <= {1'b0, row_q};
			end else begin
				o_row_scan_index <= 5'h1F - {1'b0, row_q};
			end
		end
	end
endmodule // lrc_config

// ===== verif/lrc_config_props.sv
// Checker of reset pin, role and row relations.
// Assumes binding to lrc_config.
`timescale 1ns/1ps
module lrc_config_props (
	input wire logic i_clk, i_reset, i_rst_if_pin, i_master_strap, o_frame_polarity,
	input wire logic o_chip_reset, o_is_master, o_bias_invert,
	input wire logic [4:0] o_row_scan_index,
	input wire lrc_pkg::lrc_if_t o_if_type
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// Reset pin
	property p_edge; $changed(i_rst_if_pin) |=> o_chip_reset; endproperty
	a_edge: assert property (p_edge) else $error("edge");
	property p_steady; $stable(i_rst_if_pin) [*6] |-> !o_chip_reset; endproperty
	a_steady: assert property (p_steady) else $error("level");
	property p_len; $rose(o_chip_reset) |-> o_chip_reset [*4] ##1 !o_chip_reset; endproperty
	a_len: assert property (p_len) else $error("pulse");
	// Cycles the pin has held its level since its last change, saturating
	logic [3:0] stab_q;
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			stab_q <= 4'h0;
		end else if ($changed(i_rst_if_pin)) begin
			stab_q <= 4'h0;
		end else if (stab_q != 4'hF) begin
			stab_q <= stab_q + 4'h1;
		end
	end
	property p_sel;
		stab_q == 4'hA && $stable(i_rst_if_pin) |-> o_if_type == i_rst_if_pin;
	endproperty
	a_sel: assert property (p_sel) else $error("select");
	property p_hold;
		$changed(o_if_type) |-> $past(i_rst_if_pin, 11) != $past(i_rst_if_pin, 12);
	endproperty
	a_hold: assert property (p_hold) else $error("hold");
	// Role, frame and rows
	property p_role; $fell(o_chip_reset) |-> o_is_master == $past(i_master_strap); endproperty
	a_role: assert property (p_role) else $error("role");
	property p_bias;
		o_is_master && $past(o_is_master) |-> o_bias_invert == $past(o_frame_polarity);
	endproperty
	a_bias: assert property (p_bias) else $error("bias");
	property p_row;
		$changed(o_row_scan_index) && $stable(o_row_scan_index[4]) && !o_chip_reset
			&& !$past(o_chip_reset) |-> o_row_scan_index[3:0] == (o_row_scan_index[4] ?
			$past(o_row_scan_index[3:0]) - 4'h1 : $past(o_row_scan_index[3:0]) + 4'h1);
	endproperty
	a_row: assert property (p_row) else $error("order");
	c_edge: cover property ($rose(o_chip_reset));
	c_mst: cover property ($rose(o_is_master));
	c_68: cover property (o_if_type == lrc_pkg::LRC_IF_68);
endmodule // lrc_config_props
bind lrc_config lrc_config_props props_u (.*);

// ===== verif/lrc_peer.sv
// Peer driver: oscillator source, frame when it is master.
// Assumes the bench resolves the frame wire.
`timescale 1ns/1ps
module lrc_peer (
	input wire logic i_clk,
	input wire logic i_drive,
	output logic o_frame,
	output logic o_osc
);
	logic [5:0] cnt_q = 6'h00;
	// Divider
	always_ff @(posedge i_clk) cnt_q <= cnt_q + 6'h01;
	// Released frame shows a busy pattern
	assign o_osc = cnt_q[1];
	assign o_frame = i_drive ? cnt_q[5] : cnt_q[0];
endmodule // lrc_peer

// ===== verif/tb_lrc_config.sv
// Bench for lrc_config.
// Assumes lrc_peer on the frame link.
`timescale 1ns/1ps
module tb_lrc_config;
	logic i_clk = 0, rs = 1, pin = 0, st = 0, fo, fn, bo, bn, cr, m, bi, fp, osc;
	lrc_pkg::lrc_if_t it;
	logic [4:0] ix;
	int error_cnt = 0, comparisons = 0;
	// Wires resolved from enables
	wire fr = fn ? fp : fo;
	wire ob = bn ? osc : bo;
	always #5 i_clk = ~i_clk;
	lrc_peer peer_u (.i_clk(i_clk), .i_drive(fn), .o_frame(fp), .o_osc(osc));
	lrc_config dut_u (.i_clk(i_clk), .i_reset(rs), .i_ce(1'b1), .i_rst_if_pin(pin),
		.i_master_strap(st), .i_frame_polarity(fr), .o_frame_polarity(fo),
		.o_frame_polarity_oe_n(fn), .i_oscillator_pin_a(osc), .i_oscillator_pin_b(ob),
		.o_oscillator_pin_b(bo), .o_oscillator_pin_b_oe_n(bn), .o_chip_reset(cr),
		.o_if_type(it), .o_is_master(m), .o_bias_invert(bi), .o_row_scan_step(),
		.o_row_scan_index(ix));
	task chk(input logic c, input string s);
		comparisons++;
		if (!c) begin
			error_cnt++;
			$display("unexpected %0t %s", $time, s);
		end
	endtask
	task cyc(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	// Pin edge, pulse, choice
	task t_pin(input lrc_pkg::lrc_if_t e);
		@(posedge i_clk) pin <= e;
		cyc(2);
		chk(cr === 1'b1, "reset");
		cyc(11);
		chk(it === e && cr === 1'b0, "if");
	endtask
	// Role, pins, rows, frame
	task t_role(input logic s, input lrc_pkg::lrc_if_t e);
		int n;
		logic b;
		n = 0;
		@(posedge i_clk) st <= s;
		t_pin(e);
		chk(m === s && fn === !s && bn === !s, "role");
		b = bi;
		repeat (300) begin
			cyc(1);
			n += (bi !== b);
			b = bi;
		end
		chk(ix[4] === !s && n > 0, "rows");
		$display("role %0d done", s);
	endtask
	// Edge in mid-settle
	task t_glitch;
		@(posedge i_clk) pin <= 1'b1;
		cyc(5);
		@(posedge i_clk) pin <= 1'b0;
		cyc(12);
		chk(it === lrc_pkg::LRC_IF_80, "glitch");
		$display("glitch done");
	endtask
	task stop_test;
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Sequence
	initial begin
		repeat (8) @(posedge i_clk);
		rs <= 1'b0;
		t_role(1'b1, lrc_pkg::LRC_IF_68);
		t_role(1'b0, lrc_pkg::LRC_IF_80);
		t_glitch;
		stop_test;
	end
	// Watchdog
	initial begin
		#20us;
		error_cnt++;
		stop_test;
	end
endmodule // tb_lrc_config
